//--- hw/fpx_pkg.sv
// shared constants and types for the floating-point status and approximation unit
package fpx_pkg;
	localparam int SIGN_POS    = 81;
	localparam int EXP_HI      = 80;
	localparam int EXP_LO      = 64;
	localparam int SIG_HI      = 63;
	localparam int EXP_W       = 17;
	localparam int SIG_W       = 64;
	localparam int REG_W       = 82;
	localparam int NUM_FIELDS  = 4;
	localparam int FIELD_W     = 13;
	// field layout: [1:0] rounding, [3:2] precision_control, [4] widest_exponent_select,
	// [5] trap disable all, [11:6] flags v,d,z,o,u,i, [12] reserved
	localparam int F_RC_LO     = 0;
	localparam int F_PC_LO     = 2;
	localparam int F_WRE       = 4;
	localparam int F_TD        = 5;
	localparam int F_FLAG_LO   = 6;
	localparam int FLAG_W      = 6;
	localparam logic [12:0] FIELD_RST = 13'h0020;
	localparam logic [16:0] EXP_BIAS  = 17'h0ffff;
	localparam logic [16:0] EXP_MAX   = 17'h1ffff;
	// assist window: exponents beyond these bounds go to the handler
	localparam logic [16:0] ASSIST_HI = 17'h13ffe;
	localparam logic [16:0] ASSIST_LO = 17'h0c001;
	localparam logic [3:0]  REG_STATUS  = 4'h0;
	localparam logic [3:0]  REG_IRQ_ST  = 4'h1;
	localparam logic [3:0]  REG_IRQ_MSK = 4'h2;
	localparam logic [3:0]  REG_LOAD    = 4'h3;
	localparam logic [3:0]  REG_FLAG_CLR = 4'h4;
	localparam int IRQ_W = 3;
	typedef enum logic [3:0] {
		FPX_OP_RCPA, FPX_OP_RSQRTA, FPX_OP_MIN, FPX_OP_MAX,
		FPX_OP_AMIN, FPX_OP_AMAX, FPX_OP_CLASS, FPX_OP_LOAD
	} fpx_op_t;
	typedef enum logic [1:0] {FPX_MEM_S, FPX_MEM_D, FPX_MEM_E} fpx_mem_t;
endpackage

//--- hw/fpx_recip_est.sv
// reciprocal and reciprocal square-root estimate with special-case screening
`timescale 1ns/1ns
module fpx_recip_est #(
	parameter int TBL_BITS = 8
) (
	input  wire logic [81:0] num,
	input  wire logic [81:0] den,
	input  wire logic        is_sqrt,
	output logic      [81:0] result,
	output logic             refine,
	output logic             assist,
	output logic             flag_z,
	output logic             flag_v,
	output logic             flag_d
);
	if (TBL_BITS < 1 || TBL_BITS > 16)
	begin : g_bad_tbl
		$error("fpx_recip_est: TBL_BITS out of range");
	end
	logic [16:0] de;
	logic [16:0] ne;
	logic        d_zero;
	logic        d_inf;
	logic        d_nan;
	logic        n_nan;
	logic        n_inf;
	logic [TBL_BITS-1:0] frac;
	logic [TBL_BITS-1:0] est;
	logic [TBL_BITS:0]   mant;
	logic [2*TBL_BITS+1:0] quo;
	logic [16:0] rexp;
	always_comb
	begin
		de     = den[fpx_pkg::EXP_HI:fpx_pkg::EXP_LO];
		ne     = num[fpx_pkg::EXP_HI:fpx_pkg::EXP_LO];
		d_zero = (den[fpx_pkg::SIG_HI:0] == 64'h0);
		d_inf  = (de == fpx_pkg::EXP_MAX) && (den[62:0] == 63'h0);
		d_nan  = (de == fpx_pkg::EXP_MAX) && (den[62:0] != 63'h0);
		n_nan  = !is_sqrt && (ne == fpx_pkg::EXP_MAX) && (num[62:0] != 63'h0);
		n_inf  = !is_sqrt && (ne == fpx_pkg::EXP_MAX) && (num[62:0] == 63'h0);
		frac   = den[62 -: TBL_BITS];
		// quotient of the truncated significand, good to TBL_BITS fraction bits
		mant   = {1'b1, frac};
		quo    = {1'b1, {(2*TBL_BITS+1){1'b0}}} / {{(TBL_BITS+1){1'b0}}, mant};
		// square-root estimate only promises predicate and screening behaviour
		est    = is_sqrt ? ~frac : quo[TBL_BITS-1:0];
		if (is_sqrt)
			rexp = fpx_pkg::EXP_BIAS - ((de - fpx_pkg::EXP_BIAS) >>> 1) - 17'h1;
		else
			rexp = (fpx_pkg::EXP_BIAS << 1) - de - ((frac == '0) ? 17'h0 : 17'h1);
		result = {den[fpx_pkg::SIGN_POS], rexp, 1'b1, est, {(63-TBL_BITS){1'b0}}};
		refine = 1'b1;
		assist = 1'b0;
		flag_z = 1'b0;
		flag_v = 1'b0;
		flag_d = (de == 17'h0) && !d_zero;
		// special pairs: final quotient written, predicate cleared
		if (d_nan || n_nan)
		begin
			result = {1'b0, fpx_pkg::EXP_MAX, 2'b11, 62'h0};
			refine = 1'b0;
			flag_v = 1'b1;
		end
		else if (is_sqrt && den[fpx_pkg::SIGN_POS] && !d_zero)
		begin
			result = {1'b0, fpx_pkg::EXP_MAX, 2'b11, 62'h0};
			refine = 1'b0;
			flag_v = 1'b1;
		end
		else if (d_zero)
		begin
			result = {den[fpx_pkg::SIGN_POS] ^ num[fpx_pkg::SIGN_POS], fpx_pkg::EXP_MAX,
				1'b1, 63'h0};
			refine = 1'b0;
			flag_z = !n_inf;
		end
		else if (d_inf)
		begin
			result = {den[fpx_pkg::SIGN_POS] ^ num[fpx_pkg::SIGN_POS], 81'h0};
			refine = 1'b0;
			flag_v = n_inf;
		end
		else if (de > fpx_pkg::ASSIST_HI || de < fpx_pkg::ASSIST_LO
			|| (!is_sqrt && (ne > fpx_pkg::ASSIST_HI || ne < fpx_pkg::ASSIST_LO)
			&& num[fpx_pkg::SIG_HI:0] != 64'h0))
		begin
			// far out of range: a handler supplies the quotient
			assist = 1'b1;
			refine = 1'b0;
		end
	end
endmodule

//--- hw/fpx_unit.sv
// floating-point status fields, approximation, min/max and classify unit
`timescale 1ns/1ns
// Behaviour
// - the reciprocal estimate is 8 bits accurate and sets the refine predicate when iteration works.
// - special operand pairs give the final quotient in the destination and clear the predicate.
// - operands far outside every exponent range raise a software assist fault instead.
// - the status register holds one main field and three further fields of the same layout.
// - flags of an operation go only into the field it names; the interrupt status is shared by all fields.
// - loads convert single, double and extended operands into the one register format.
// - single and double precision come from the opcode, extended precision from the field.
// - each field holds precision, range, rounding and trap controls; refined estimates honour the first three, nothing reads the trap control.
// - every operation picks its own field, so environments change with no reconfiguration.
// - minimum yields a when a<b else b; maximum yields b when a<b else a.
// - classify writes a true predicate and its complement.
// - each register value is 82 bits: sign, 17-bit exponent, 64-bit significand.
// - a failed less-than, NaNs included, makes minimum return its second operand.
// - absolute min and max compare magnitudes and otherwise select as min and max.
module fpx_unit (
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic        op_valid,
	input  wire logic [3:0]  op_code,
	input  wire logic [1:0]  op_field,
	input  wire logic [1:0]  op_prec,
	input  wire logic [8:0]  op_class_mask,
	input  wire logic [81:0] op_a,
	input  wire logic [81:0] op_b,
	input  wire logic [1:0]  op_mem_type,
	input  wire logic [79:0] op_mem_data,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic             res_valid,
	output logic      [81:0] res_value,
	output logic             refine_predicate,
	output logic             pred_false,
	output logic             assist_fault,
	output logic             irq
);
	logic [fpx_pkg::FIELD_W-1:0] fp_status_reg_ff [fpx_pkg::NUM_FIELDS];
	logic [fpx_pkg::IRQ_W-1:0]   irq_st_ff;
	logic [fpx_pkg::IRQ_W-1:0]   irq_msk_ff;
	logic [1:0]                  field_sel_ff;
	logic [81:0]                 est_res;
	logic                        est_refine;
	logic                        est_assist;
	logic                        est_z;
	logic                        est_v;
	logic                        est_d;
	logic                        is_est;
	logic [81:0]                 nxt_value;
	logic                        nxt_pred;
	logic                        nxt_npred;
	logic                        nxt_assist;
	logic [fpx_pkg::FLAG_W-1:0]  new_flags;
	logic [fpx_pkg::FIELD_W-1:0] sel_field;
	logic                        lt;
	logic                        any_nan;

	function automatic logic is_nan(input logic [81:0] v);
		is_nan = (v[fpx_pkg::EXP_HI:fpx_pkg::EXP_LO] == fpx_pkg::EXP_MAX)
			&& (v[62:0] != 63'h0);
	endfunction

	// signed-magnitude less-than; false for unordered operands
	function automatic logic fp_lt(input logic [81:0] a, input logic [81:0] b);
		logic [80:0] ma;
		logic [80:0] mb;
		ma = a[80:0];
		mb = b[80:0];
		if (is_nan(a) || is_nan(b))
			fp_lt = 1'b0;
		else if (ma == 81'h0 && mb == 81'h0)
			fp_lt = 1'b0;
		else if (a[fpx_pkg::SIGN_POS] != b[fpx_pkg::SIGN_POS])
			fp_lt = a[fpx_pkg::SIGN_POS];
		else if (a[fpx_pkg::SIGN_POS])
			fp_lt = ma > mb;
		else
			fp_lt = ma < mb;
	endfunction

	// class bits: 0 pos,1 neg,2 zero,3 unnorm,4 norm,5 inf,6 qnan,7 snan,8 natval-free
	function automatic logic fp_class(input logic [81:0] v, input logic [8:0] m);
		logic [16:0] e;
		logic        sgn;
		logic        kind;
		e    = v[fpx_pkg::EXP_HI:fpx_pkg::EXP_LO];
		sgn  = v[fpx_pkg::SIGN_POS];
		kind = 1'b0;
		if (v[fpx_pkg::SIG_HI:0] == 64'h0 && e != fpx_pkg::EXP_MAX)
			kind = m[2];
		else if (e == fpx_pkg::EXP_MAX && v[62:0] == 63'h0)
			kind = m[5];
		else if (e == fpx_pkg::EXP_MAX)
			kind = v[62] ? m[6] : m[7];
		else if (!v[fpx_pkg::SIG_HI])
			kind = m[3];
		else
			kind = m[4];
		fp_class = kind && (sgn ? m[1] : m[0]);
	endfunction

	// widen a memory operand into the register format
	function automatic logic [81:0] mem_load(input logic [1:0] t, input logic [79:0] d);
		logic [16:0] e;
		logic        nz;
		mem_load = 82'h0;
		e        = 17'h0;
		nz       = 1'b0;
		case (t)
			fpx_pkg::FPX_MEM_S:
			begin
				nz = d[30:23] != 8'h0;
				if (d[30:23] == 8'hff)
					e = fpx_pkg::EXP_MAX;
				else if (nz)
					e = 17'({9'h0, d[30:23]} + 17'h0ff80);
				else if (d[22:0] != 23'h0)
					e = 17'h0ff81;
				mem_load = {d[31], e, nz, d[22:0], 40'h0};
			end
			fpx_pkg::FPX_MEM_D:
			begin
				nz = d[62:52] != 11'h0;
				if (d[62:52] == 11'h7ff)
					e = fpx_pkg::EXP_MAX;
				else if (nz)
					e = 17'({6'h0, d[62:52]} + 17'h0fc00);
				else if (d[51:0] != 52'h0)
					e = 17'h0fc01;
				mem_load = {d[63], e, nz, d[51:0], 11'h0};
			end
			fpx_pkg::FPX_MEM_E:
			begin
				if (d[78:64] == 15'h7fff)
					e = fpx_pkg::EXP_MAX;
				else if (d[78:64] != 15'h0)
					e = 17'({2'h0, d[78:64]} + 17'h0c000);
				mem_load = {d[79], e, d[63:0]};
			end
			default: mem_load = 82'h0;
		endcase
	endfunction

	// precision from opcode, or from the field when extended is asked
	function automatic logic [81:0] apply_prec(input logic [81:0] v, input logic [1:0] p,
		input logic [fpx_pkg::FIELD_W-1:0] f);
		logic [1:0] eff;
		logic [1:0] rc;
		logic [63:0] keep;
		logic        up;
		eff  = (p == 2'h3) ? f[fpx_pkg::F_PC_LO +: 2] : p;
		rc   = f[fpx_pkg::F_RC_LO +: 2];
		keep = (eff == 2'h0) ? 64'hffffff0000000000 :
			(eff == 2'h1 || eff == 2'h2) ? 64'hfffffffffffff800 : 64'hffffffffffffffff;
		up   = (rc == 2'h1 && v[fpx_pkg::SIGN_POS]) || (rc == 2'h2 && !v[fpx_pkg::SIGN_POS]);
		apply_prec = v;
		if (v[fpx_pkg::EXP_HI:fpx_pkg::EXP_LO] != fpx_pkg::EXP_MAX)
		begin
			apply_prec[63:0] = v[63:0] & keep;
			// directed rounding nudges by one kept ulp; carry-out is clipped
			if (up && (v[63:0] & ~keep) != 64'h0 && (v[63:0] | ~keep) != 64'hffffffffffffffff)
				apply_prec[63:0] = (v[63:0] & keep) + (~keep + 64'h1);
		end
		// without widest range, clamp large exponents down to the top of the extended span
		if (!f[fpx_pkg::F_WRE] && v[fpx_pkg::EXP_HI:fpx_pkg::EXP_LO] != fpx_pkg::EXP_MAX
			&& v[fpx_pkg::EXP_HI:fpx_pkg::EXP_LO] > fpx_pkg::ASSIST_HI)
			apply_prec[fpx_pkg::EXP_HI:fpx_pkg::EXP_LO] = fpx_pkg::ASSIST_HI;
	endfunction

	fpx_recip_est #(
		.TBL_BITS (8)
	) u_est (
		.num     (op_a),
		.den     (op_b),
		.is_sqrt (op_code == fpx_pkg::FPX_OP_RSQRTA),
		.result  (est_res),
		.refine  (est_refine),
		.assist  (est_assist),
		.flag_z  (est_z),
		.flag_v  (est_v),
		.flag_d  (est_d)
	);

	always_comb
	begin
		sel_field  = fp_status_reg_ff[op_field];
		is_est     = (op_code == fpx_pkg::FPX_OP_RCPA) || (op_code == fpx_pkg::FPX_OP_RSQRTA);
		any_nan    = is_nan(op_a) || is_nan(op_b);
		lt         = 1'b0;
		nxt_value  = op_b;
		nxt_pred   = 1'b0;
		nxt_npred  = 1'b0;
		nxt_assist = 1'b0;
		new_flags  = '0;
		case (op_code)
			fpx_pkg::FPX_OP_RCPA, fpx_pkg::FPX_OP_RSQRTA:
			begin
				nxt_value  = est_res;
				nxt_pred   = est_refine;
				nxt_npred  = 1'b0;
				nxt_assist = est_assist;
				new_flags  = {3'b000, est_z, est_d, est_v};
			end
			fpx_pkg::FPX_OP_MIN:
			begin
				lt        = fp_lt(op_a, op_b);
				nxt_value = lt ? op_a : op_b;
				new_flags = {5'b0, any_nan};
			end
			fpx_pkg::FPX_OP_MAX:
			begin
				lt        = fp_lt(op_a, op_b);
				nxt_value = lt ? op_b : op_a;
				new_flags = {5'b0, any_nan};
			end
			fpx_pkg::FPX_OP_AMIN:
			begin
				lt        = fp_lt({1'b0, op_a[80:0]}, {1'b0, op_b[80:0]});
				nxt_value = lt ? op_a : op_b;
				new_flags = {5'b0, any_nan};
			end
			fpx_pkg::FPX_OP_AMAX:
			begin
				lt        = fp_lt({1'b0, op_a[80:0]}, {1'b0, op_b[80:0]});
				nxt_value = lt ? op_b : op_a;
				new_flags = {5'b0, any_nan};
			end
			fpx_pkg::FPX_OP_CLASS:
			begin
				nxt_pred  = fp_class(op_a, op_class_mask);
				nxt_npred = !nxt_pred;
				nxt_value = op_a;
			end
			fpx_pkg::FPX_OP_LOAD:
				nxt_value = mem_load(op_mem_type, op_mem_data);
			default: nxt_value = op_b;
		endcase
		// min and max hand their operand back untouched, so no rounding there
		if (is_est && est_refine)
			nxt_value = apply_prec(nxt_value, op_prec, sel_field);
	end

	// status fields: operations OR flags into the named field only
	genvar gi;
	generate
		for (gi = 0; gi < fpx_pkg::NUM_FIELDS; gi++)
		begin : g_field
			always_ff @(posedge clk_sys or negedge rst_b)
			begin
				if (!rst_b)
					fp_status_reg_ff[gi] <= fpx_pkg::FIELD_RST;
				else
				begin
					logic [fpx_pkg::FLAG_W-1:0] flg;
					logic [fpx_pkg::FLAG_W-1:0] hit;
					flg = fp_status_reg_ff[gi][fpx_pkg::F_FLAG_LO +: fpx_pkg::FLAG_W];
					hit = (op_valid && op_field == 2'(gi)) ? new_flags : '0;
					if (reg_wr && reg_addr == fpx_pkg::REG_STATUS)
					begin
						fp_status_reg_ff[gi][5:0] <= reg_wdata[gi*8 +: 6];
						// write-one clears; a same-cycle raise still wins
						flg = flg & ~{reg_wdata[gi*8 + 7 -: 2], 4'h0};
					end
					if (reg_wr && reg_addr == fpx_pkg::REG_FLAG_CLR)
						flg = flg & ~reg_wdata[gi*8 +: fpx_pkg::FLAG_W];
					fp_status_reg_ff[gi][fpx_pkg::F_FLAG_LO +: fpx_pkg::FLAG_W] <= flg | hit;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			res_valid        <= 1'b0;
			res_value        <= '0;
			refine_predicate <= 1'b0;
			pred_false       <= 1'b0;
			assist_fault     <= 1'b0;
			field_sel_ff     <= 2'h0;
		end
		else
		begin
			res_valid        <= op_valid && !(is_est && est_assist);
			assist_fault     <= op_valid && is_est && est_assist;
			if (op_valid)
			begin
				res_value        <= nxt_value;
				refine_predicate <= nxt_pred;
				pred_false       <= nxt_npred;
				field_sel_ff     <= op_field;
			end
		end
	end

	// interrupt: 0 invalid, 1 zero-divide, 2 assist fault
	logic [fpx_pkg::IRQ_W-1:0] irq_ev;
	assign irq_ev = op_valid ? {is_est && est_assist, new_flags[2], new_flags[0]} : '0;
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			irq_st_ff  <= '0;
			irq_msk_ff <= '0;
			irq        <= 1'b0;
		end
		else
		begin
			if (reg_wr && reg_addr == fpx_pkg::REG_IRQ_ST)
				irq_st_ff <= (irq_st_ff & ~reg_wdata[fpx_pkg::IRQ_W-1:0]) | irq_ev;
			else
				irq_st_ff <= irq_st_ff | irq_ev;
			if (reg_wr && reg_addr == fpx_pkg::REG_IRQ_MSK)
				irq_msk_ff <= reg_wdata[fpx_pkg::IRQ_W-1:0];
			irq <= |(irq_st_ff & irq_msk_ff);
		end
	end

	// fields packed one per byte of the status word
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			reg_rdata <= '0;
		else if (reg_rd)
		begin
			case (reg_addr)
				fpx_pkg::REG_STATUS:
					reg_rdata <= {fp_status_reg_ff[3][11:6], 2'b0, fp_status_reg_ff[2][11:6], 2'b0,
						fp_status_reg_ff[1][11:6], 2'b0, fp_status_reg_ff[0][11:6], 2'b0}
						| {2'b0, fp_status_reg_ff[3][5:0], 2'b0, fp_status_reg_ff[2][5:0],
						2'b0, fp_status_reg_ff[1][5:0], 2'b0, fp_status_reg_ff[0][5:0]};
				fpx_pkg::REG_IRQ_ST:  reg_rdata <= {29'h0, irq_st_ff};
				fpx_pkg::REG_IRQ_MSK: reg_rdata <= {29'h0, irq_msk_ff};
				fpx_pkg::REG_LOAD:    reg_rdata <= {30'h0, field_sel_ff};
				default:              reg_rdata <= 32'h0;
			endcase
		end
		else
			reg_rdata <= 32'h0;
	end
endmodule

//--- test/fpx_unit_chk.sv
// concurrent checks on the ports of the floating-point status and approximation unit
`timescale 1ns/1ns
module fpx_unit_chk (
	input wire logic        clk_sys,
	input wire logic        rst_b,
	input wire logic        op_valid,
	input wire logic [3:0]  op_code,
	input wire logic [81:0] op_a,
	input wire logic [81:0] op_b,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        res_valid,
	input wire logic [81:0] res_value,
	input wire logic        refine_predicate,
	input wire logic        pred_false,
	input wire logic        assist_fault
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// nan test needs a nonzero fraction below the integer bit
	wire nan_a = op_a[80:64] == fpx_pkg::EXP_MAX && op_a[62:0] != 63'h0;
	wire fin_a = op_a[80:64] != fpx_pkg::EXP_MAX;
	wire fin_b = op_b[80:64] != fpx_pkg::EXP_MAX;
	wire est_op = op_valid && op_code <= 4'h1;
	wire a_unit = op_a[80:64] == fpx_pkg::EXP_BIAS;

	a_res_has_cause: assert property (res_valid |-> $past(op_valid))
		else $error("result without an issued operation");
	a_assist_no_res: assert property (assist_fault |-> !res_valid && $past(op_code) <= 4'h1)
		else $error("assist fault with result or from a non-estimate op");
	a_plain_op_done: assert property (op_valid && op_code > 4'h1 && op_code < 4'h8
		|=> res_valid && !assist_fault)
		else $error("plain operation gave no result");
	a_class_pair: assert property (op_valid && op_code == 4'h6
		|=> pred_false != refine_predicate)
		else $error("classify predicates not complementary");
	a_min_nan_b: assert property (op_valid && op_code == 4'h2 && nan_a
		|=> res_value == $past(op_b))
		else $error("minimum with nan first operand did not return second");
	a_max_nan_a: assert property (op_valid && op_code == 4'h3 && nan_a
		|=> res_value == $past(op_a))
		else $error("maximum with failed compare did not return first");
	a_amin_mag: assert property (op_valid && op_code == 4'h4 && fin_a && fin_b
		&& op_a[80:0] < op_b[80:0] |=> res_value == $past(op_a))
		else $error("absolute minimum ignored magnitude order");
	a_zero_div: assert property (est_op && op_code == 4'h0 && op_b[80:0] == 81'h0
		&& a_unit |=> res_valid && !refine_predicate)
		else $error("finite over zero did not give final result");
	// positive normal divisor only: zero or negative root operands are special cases
	a_assist_range: assert property (est_op && a_unit && fin_b && op_b[63]
		&& !op_b[81] && op_b[80:64] > fpx_pkg::ASSIST_HI |=> assist_fault)
		else $error("out of range operand gave no assist fault");
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data outside read answer cycle");

	c_min: cover property (op_valid && op_code == 4'h2 ##1 res_valid);
	c_assist: cover property (assist_fault);
	c_class: cover property (op_valid && op_code == 4'h6);
endmodule

bind fpx_unit fpx_unit_chk u_chk (
	.clk_sys(clk_sys), .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code),
	.op_a(op_a), .op_b(op_b), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.res_valid(res_valid), .res_value(res_value), .refine_predicate(refine_predicate),
	.pred_false(pred_false), .assist_fault(assist_fault)
);

//--- test/fpx_issue_model.sv
// issue-side model that presents one operation per cycle to the unit
`timescale 1ns/1ns
module fpx_issue_model (
	input  wire logic        clk_sys,
	output logic             op_valid,
	output logic [3:0]       op_code,
	output logic [1:0]       op_field,
	output logic [8:0]       op_class_mask,
	output logic [81:0]      op_a,
	output logic [81:0]      op_b,
	output logic [79:0]      op_mem_data
);
	initial
	begin
		op_valid = 1'b0;
		op_code = 4'h0;
		op_field = 2'h0;
		op_class_mask = 9'h000;
		op_a = 82'h0;
		op_b = 82'h0;
		op_mem_data = 80'h0;
	end
	// called just after an edge; back-to-back calls keep valid high
	task issue(input logic [3:0] c, input logic [1:0] f, input logic [81:0] a,
		input logic [81:0] b, input logic [8:0] m, input logic [79:0] d);
		op_valid <= 1'b1;
		op_code <= c;
		op_field <= f;
		op_a <= a;
		op_b <= b;
		op_class_mask <= m;
		op_mem_data <= d;
		@(posedge clk_sys);
		#1;
	endtask
	// idle operands flip so a stale value never looks valid
	task idle;
		op_valid <= 1'b0;
		op_a <= ~op_a;
		op_b <= ~op_b;
		op_mem_data <= ~op_mem_data;
		op_class_mask <= ~op_class_mask;
		@(posedge clk_sys);
		#1;
	endtask
endmodule

//--- test/fp_status_fields_and_approx_ops_tb_top.sv
// self-checking bench for the floating-point status and approximation unit
`timescale 1ns/1ns
module fp_status_fields_and_approx_ops_tb_top;
	logic        clk_sys = 1'b0;
	logic        rst_b = 1'b0;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [1:0]  op_prec = 2'h1;
	logic [1:0]  op_mem_type = 2'h0;
	logic        op_valid;
	logic [3:0]  op_code;
	logic [1:0]  op_field;
	logic [8:0]  op_class_mask;
	logic [81:0] op_a;
	logic [81:0] op_b;
	logic [79:0] op_mem_data;
	logic [31:0] reg_rdata;
	logic        res_valid;
	logic [81:0] res_value;
	logic        refine_predicate;
	logic        pred_false;
	logic        assist_fault;
	logic        irq;
	int          fail_count = 0;
	int          n_checks = 0;
	localparam logic [63:0] SIG1 = 64'h8000000000000000;
	localparam logic [81:0] ONE  = {1'b0, fpx_pkg::EXP_BIAS, SIG1};
	localparam logic [81:0] TWO  = {1'b0, 17'h10000, SIG1};
	localparam logic [81:0] NTWO = {1'b1, 17'h10000, SIG1};
	localparam logic [81:0] THREE = {1'b0, 17'h10000, 64'hc000000000000000};
	localparam logic [81:0] QNAN = {1'b0, fpx_pkg::EXP_MAX, 64'hc000000000000000};
	localparam logic [81:0] HUGE = {1'b0, 17'h14000, SIG1};

	always #5 clk_sys = ~clk_sys;

	fpx_issue_model iss (.clk_sys(clk_sys), .op_valid(op_valid), .op_code(op_code),
		.op_field(op_field), .op_class_mask(op_class_mask), .op_a(op_a), .op_b(op_b),
		.op_mem_data(op_mem_data));

	// precision and memory type are driven by the scenarios that need them, not by the issue model
	fpx_unit dut (.clk_sys(clk_sys), .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code),
		.op_field(op_field), .op_prec(op_prec), .op_class_mask(op_class_mask), .op_a(op_a),
		.op_b(op_b), .op_mem_type(op_mem_type), .op_mem_data(op_mem_data), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.res_valid(res_valid), .res_value(res_value), .refine_predicate(refine_predicate),
		.pred_false(pred_false), .assist_fault(assist_fault), .irq(irq));

	task finish_test;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task chk(input logic [81:0] got, input logic [81:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task wr(input logic [3:0] a, input logic [31:0] d);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		#1;
	endtask

	// read data stands only in the cycle after the strobe
	task rd_chk(input logic [3:0] a, input logic [31:0] e);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask

	task mm(input logic [3:0] c, input logic [81:0] a, input logic [81:0] b,
		input logic [81:0] e);
		iss.issue(c, 2'h1, a, b, 9'h000, 80'h0);
		chk(res_value, e);
	endtask

	task t_reset;
		rd_chk(fpx_pkg::REG_STATUS, 32'h20202020);
		rd_chk(4'hf, 32'h0);
	endtask

	task t_minmax;
		mm(4'h2, QNAN, ONE, ONE);
		mm(4'h3, QNAN, ONE, QNAN);
		mm(4'h2, ONE, QNAN, QNAN);
		mm(4'h2, ONE, TWO, ONE);
		mm(4'h3, ONE, TWO, TWO);
		mm(4'h4, NTWO, ONE, ONE);
		mm(4'h5, NTWO, ONE, NTWO);
		mm(4'h4, ONE, NTWO, ONE);
		iss.idle;
	endtask

	// three estimates back to back in different fields
	task t_recip;
		iss.issue(4'h0, 2'h2, ONE, 82'h0, 9'h000, 80'h0);
		chk(res_value[80:64], fpx_pkg::EXP_MAX);
		chk({res_valid, refine_predicate}, 2'b10);
		iss.issue(4'h0, 2'h0, ONE, TWO, 9'h000, 80'h0);
		chk(res_value, {1'b0, 17'h0fffe, SIG1});
		chk(refine_predicate, 1'b1);
		// extended precision from field 3 (single): an 8-bit estimate survives it
		op_prec <= 2'h3;
		iss.issue(4'h0, 2'h3, ONE, THREE, 9'h000, 80'h0);
		chk(res_value, {1'b0, 17'h0fffd, 1'b1, 8'h55, 55'h0});
		iss.idle;
		rd_chk(fpx_pkg::REG_STATUS, 32'h20302420);
	endtask

	task t_irq;
		rd_chk(fpx_pkg::REG_IRQ_ST, 32'h3);
		wr(fpx_pkg::REG_IRQ_MSK, 32'h2);
		@(posedge clk_sys);
		#1;
		chk(irq, 1'b1);
		wr(fpx_pkg::REG_IRQ_ST, 32'h2);
		@(posedge clk_sys);
		#1;
		chk(irq, 1'b0);
		rd_chk(fpx_pkg::REG_IRQ_ST, 32'h1);
		rd_chk(fpx_pkg::REG_STATUS, 32'h20302420);
		wr(fpx_pkg::REG_FLAG_CLR, 32'h00000100);
		rd_chk(fpx_pkg::REG_STATUS, 32'h20302020);
	endtask

	task t_assist;
		iss.issue(4'h1, 2'h0, ONE, HUGE, 9'h000, 80'h0);
		chk(assist_fault, 1'b1);
		chk(res_valid, 1'b0);
		iss.idle;
		rd_chk(fpx_pkg::REG_IRQ_ST, 32'h5);
	endtask

	task t_class;
		iss.issue(4'h6, 2'h0, ONE, ONE, 9'h011, 80'h0);
		chk({refine_predicate, pred_false}, 2'b10);
		iss.issue(4'h6, 2'h0, ONE, ONE, 9'h01e, 80'h0);
		chk({refine_predicate, pred_false}, 2'b01);
		iss.idle;
	endtask

	task t_load;
		op_mem_type <= 2'h0;
		iss.issue(4'h7, 2'h0, 82'h0, 82'h0, 9'h000, 80'h3f800000);
		chk(res_value, ONE);
		op_mem_type <= 2'h1;
		iss.issue(4'h7, 2'h0, 82'h0, 82'h0, 9'h000, 80'h4000000000000000);
		chk(res_value, TWO);
		op_mem_type <= 2'h2;
		iss.issue(4'h7, 2'h0, 82'h0, 82'h0, 9'h000, {1'b1, 15'h4000, SIG1});
		chk(res_value, NTWO);
		iss.idle;
	endtask

	initial
	begin
		repeat (4) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		#1;
		t_reset;
		t_minmax;
		t_recip;
		t_irq;
		t_assist;
		t_class;
		t_load;
		finish_test;
	end

	// hang guard
	initial
	begin
		repeat (5000) @(posedge clk_sys);
		fail_count++;
		finish_test;
	end
endmodule
